// >>> inc/diag_buf_pkg.sv
/*
  Constants, register map and state types shared by the buffer-access command engine.
  Assumes a 32-bit APB register bus and a byte-wide data stream from the bus-phase logic.
*/
package diag_buf_pkg;

  // Command operation codes
  localparam logic [7:0]  OP_WRITE_BUF   = 8'h3b;
  localparam logic [7:0]  OP_READ_BUF    = 8'h3c;

  // Mode field values
  localparam logic [2:0]  MODE_COMBINED  = 3'h0;
  localparam logic [2:0]  MODE_DATA      = 3'h2;
  localparam logic [2:0]  MODE_DESC      = 3'h3;

  // Field positions inside the 80-bit command block, byte 0 in the low bits
  localparam int          CDB_BITS       = 80;
  localparam int          F_OPCODE       = 0;
  localparam int          F_MODE         = 8;
  localparam int          F_SELECTOR     = 16;
  localparam int          F_LEN_MSB      = 48;
  localparam int          F_LEN_MID      = 56;
  localparam int          F_LEN_LSB      = 64;

  // Buffer geometry
  localparam int          BUF_BYTES      = 64;
  localparam int          BUF_AW         = 6;
  localparam logic [23:0] BUF_CAPACITY   = 24'h00_0040;
  localparam logic [2:0]  HDR_BYTES      = 3'h4;
  localparam logic [23:0] HDR_LEN24      = 24'h00_0004;

  // Sense keys: illegal request on a rejected command, none otherwise
  localparam logic [3:0]  SENSE_ILLEGAL  = 4'h5;
  localparam logic [3:0]  SENSE_NONE     = 4'h0;

  // Register byte offsets
  localparam logic [7:0]  REG_CMD_LO     = 8'h00;
  localparam logic [7:0]  REG_CMD_MID    = 8'h04;
  localparam logic [7:0]  REG_CMD_HI     = 8'h08;
  localparam logic [7:0]  REG_CTRL       = 8'h0c;
  localparam logic [7:0]  REG_STATUS     = 8'h10;
  localparam logic [7:0]  REG_AVAIL      = 8'h14;
  localparam logic [7:0]  REG_IRQ_STAT   = 8'h18;
  localparam logic [7:0]  REG_IRQ_CLR    = 8'h1c;
  localparam logic [7:0]  REG_IRQ_EN     = 8'h20;

  // Field positions
  localparam int          CTRL_START     = 0;
  localparam int          ST_BUSY        = 0;
  localparam int          ST_CHECK       = 1;
  localparam int          ST_SENSE_LSB   = 4;
  localparam int          IRQ_DONE       = 0;
  localparam int          IRQ_CHECK      = 1;

  // Reset values
  localparam logic [23:0] AVAIL_RST      = 24'h00_0000;
  localparam logic [1:0]  IRQ_EN_RST     = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_RECV = 2'b10,
    ST_FIN  = 2'b11
  } fsm_e;

endpackage : diag_buf_pkg

// >>> inc/cdb_if.sv
/*
  Carries the stored command block to the decoder and its decoded result back.
  Assumes both ends run from the same clock; the decode is purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
interface cdb_if;
  logic [79:0] cdb;
  logic [23:0] avail;
  logic        is_write;
  logic        reject;
  logic [23:0] total;
  logic [2:0]  hdr_len;
  logic [2:0]  mode;
  logic        desc_zero;

  modport user (output cdb, avail, input is_write, reject, total, hdr_len, mode, desc_zero);
  modport decoder (input cdb, avail, output is_write, reject, total, hdr_len, mode, desc_zero);
endinterface : cdb_if
`default_nettype wire

// >>> design/cdb_decode.sv
/*
  Decodes a stored read-buffer or write-buffer command block into a transfer plan.
  Assumes the command block is held stable by the engine while a command runs.
*/
`timescale 1ns/100ps
`default_nettype none
module cdb_decode
  import diag_buf_pkg::*;
(
  // Command block and result
  cdb_if.decoder d
);

  logic [7:0]  opcode;
  logic [7:0]  selector;
  logic [23:0] len;
  logic [24:0] hdr_plus_avail;

  assign opcode         = d.cdb[F_OPCODE +: 8];
  assign selector       = d.cdb[F_SELECTOR +: 8];
  assign len            = {d.cdb[F_LEN_MSB +: 8], d.cdb[F_LEN_MID +: 8], d.cdb[F_LEN_LSB +: 8]};
  assign hdr_plus_avail = {1'b0, d.avail} + {1'b0, HDR_LEN24};

  always_comb begin
    d.mode      = d.cdb[F_MODE +: 3];
    d.is_write  = 1'b0;
    d.reject    = 1'b0;
    d.total     = 24'h00_0000;
    d.hdr_len   = 3'h0;
    d.desc_zero = 1'b0;
    if (opcode == OP_READ_BUF) begin // RL4
      case (d.mode) // RL5
        MODE_COMBINED: begin
          // Selector and offset bytes are not looked at here
          d.hdr_len = HDR_BYTES; // RL6
          d.total   = ({1'b0, len} < hdr_plus_avail) ? len : hdr_plus_avail[23:0]; // RL7 RL9 RL15
        end
        MODE_DATA: begin
          d.reject = (selector != 8'h00); // RL11
          d.total  = (len < d.avail) ? len : d.avail; // RL10 RL15
        end
        MODE_DESC: begin
          d.desc_zero = (selector != 8'h00); // RL12
          d.total     = (len < HDR_LEN24) ? len : HDR_LEN24; // RL13 RL15
        end
        default: begin
          d.reject = 1'b1; // RL18
        end
      endcase
    end else if (opcode == OP_WRITE_BUF) begin
      d.is_write = 1'b1;
      d.total    = len;
      case (d.mode)
        MODE_COMBINED: begin
          // Echoed header is received first and discarded
          d.hdr_len = HDR_BYTES; // RL1
          d.reject  = (len < HDR_LEN24) || ((len - HDR_LEN24) > BUF_CAPACITY); // RL1 RL2
        end
        MODE_DATA: begin
          d.reject = (selector != 8'h00) || (len > BUF_CAPACITY); // RL2
        end
        default: begin
          d.reject = 1'b1; // RL18
        end
      endcase
    end else begin
      d.reject = 1'b1;
    end
  end

endmodule : cdb_decode
`default_nettype wire

// >>> design/diag_buf_engine.sv
/*
  Buffer-access diagnostic command engine: holds the command block, runs the
  read-buffer and write-buffer transfers against a flip-flop buffer, and reports
  check condition with an illegal-request sense key.
  Assumes the byte streams come from bus-phase logic on pclk, and a 32-bit APB master.
*/
// The APB slave port and the placing of the registers were chosen for this implementation.
// How it works
// RL1: Write transfer length counts payload plus four echoed header bytes, discarded first.
// RL2: Write longer than buffer capacity ends in check condition, illegal request.
// RL3: Initiator adds any nonzero offset to the write transfer length.
// RL4: Opcode 3C is read-buffer; bytes give mode, selector, offset, length, flags.
// RL5: Read mode 0 combined, 1 reserved, 2 data, 3 descriptor.
// RL6: Combined mode ignores bytes 2-5, sends header then stored data.
// RL7: Combined transfer stops at request or header plus all data, whichever smaller.
// RL8: Header is a zero byte then available length, most significant first.
// RL9: Payload after header is min of allocation minus four and available length.
// RL10: Data mode returns buffer bytes as one contiguous stream.
// RL11: Nonzero selector in data mode gives check condition, illegal request.
// RL12: Descriptor mode with nonzero selector returns all-zero bytes.
// RL13: Descriptor mode sends at most four bytes.
// RL14: Descriptor is a zero byte then buffer capacity, most significant first.
// RL15: Zero allocation sends nothing; otherwise it bounds header plus data.
// RL16: Initiator keeps allocation plus offset within buffer capacity.
// RL17: Initiator sets read offset to zero.
// RL18: Reserved mode values are rejected with check condition, illegal request.
`timescale 1ns/100ps
`default_nettype none
module diag_buf_engine
  import diag_buf_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Data-in stream towards the initiator
  output logic      [7:0]  dout_byte,
  output logic             dout_valid,
  input  wire logic        dout_ready,
  // Data-out stream from the initiator
  input  wire logic [7:0]  din_byte,
  input  wire logic        din_valid,
  output logic             din_ready,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    fsm_e                          fsm;
    logic [CDB_BITS-1:0]           cdb;
    logic [BUF_BYTES-1:0][7:0]     mem;
    logic [23:0]                   avail;
    logic [23:0]                   idx;
    logic                          busy;
    logic                          check;
    logic [3:0]                    sense;
    logic [1:0]                    irq_stat;
    logic [1:0]                    irq_en;
    logic                          irq;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
    logic [7:0]                    dout_byte;
    logic                          dout_valid;
    logic                          din_ready;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  cdb_if dec ();

  cdb_decode u_decode (
    .d (dec.decoder)
  );

  assign dec.cdb   = s_r.cdb;
  assign dec.avail = s_r.avail;

  logic              acc_done;
  logic              wr_done;
  logic              mapped;
  logic [31:0]       rd_word;
  logic [23:0]       hdr24;
  logic [23:0]       mem_pos;
  logic [BUF_AW-1:0] mem_ix;
  logic [7:0]        gen_byte;
  logic [1:0]        irq_set;
  logic [1:0]        irq_clr;
  logic              start;

  assign acc_done = psel && penable && s_r.pready;
  assign wr_done  = acc_done && pwrite;
  assign hdr24    = {21'h00_0000, dec.hdr_len};
  assign mem_pos  = s_r.idx - hdr24;
  assign mem_ix   = mem_pos[BUF_AW-1:0];
  assign start    = wr_done && (paddr == REG_CTRL) && pwdata[CTRL_START] && !s_r.busy;

  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      REG_CMD_LO:   rd_word = s_r.cdb[31:0];
      REG_CMD_MID:  rd_word = s_r.cdb[63:32];
      REG_CMD_HI:   rd_word = {16'h0000, s_r.cdb[79:64]};
      REG_CTRL:     rd_word = 32'h0000_0000;
      REG_STATUS: begin
        rd_word[ST_BUSY]               = s_r.busy;
        rd_word[ST_CHECK]              = s_r.check;
        rd_word[ST_SENSE_LSB +: 4]     = s_r.sense;
      end
      REG_AVAIL:    rd_word = {8'h00, s_r.avail};
      REG_IRQ_STAT: rd_word = {30'h0000_0000, s_r.irq_stat};
      REG_IRQ_CLR:  rd_word = 32'h0000_0000;
      REG_IRQ_EN:   rd_word = {30'h0000_0000, s_r.irq_en};
      default:      mapped  = 1'b0;
    endcase
  end

  // Byte generator for the data-in stream, indexed by the running byte count
  always_comb begin
    gen_byte = 8'h00;
    if (dec.mode == MODE_DESC) begin
      if (!dec.desc_zero) begin // RL12
        case (s_r.idx[1:0]) // RL14
          2'h1:    gen_byte = BUF_CAPACITY[23:16];
          2'h2:    gen_byte = BUF_CAPACITY[15:8];
          2'h3:    gen_byte = BUF_CAPACITY[7:0];
          default: gen_byte = 8'h00;
        endcase
      end
    end else if (s_r.idx < hdr24) begin
      case (s_r.idx[1:0]) // RL8
        2'h1:    gen_byte = s_r.avail[23:16];
        2'h2:    gen_byte = s_r.avail[15:8];
        2'h3:    gen_byte = s_r.avail[7:0];
        default: gen_byte = 8'h00;
      endcase
    end else begin
      gen_byte = s_r.mem[mem_ix]; // RL6 RL10
    end
  end

  always_comb begin
    s_nxt   = s_r;
    irq_set = 2'h0;
    irq_clr = 2'h0;

    // Two-cycle access phase: pready rises one cycle after penable, data loaded with it
    s_nxt.pready = psel && penable && !s_r.pready;
    if (psel && penable && !s_r.pready) begin
      s_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_word;
      s_nxt.pslverr = !mapped;
    end else begin
      // Error flag is a one-cycle pulse beside pready, so a back-to-back setup never sees it
      s_nxt.pslverr = 1'b0;
    end

    // Command block is frozen while a command runs so the decode stays stable
    if (wr_done && !s_r.busy) begin
      if (paddr == REG_CMD_LO) begin
        s_nxt.cdb[31:0] = pwdata;
      end
      if (paddr == REG_CMD_MID) begin
        s_nxt.cdb[63:32] = pwdata;
      end
      if (paddr == REG_CMD_HI) begin
        s_nxt.cdb[79:64] = pwdata[15:0];
      end
    end
    if (wr_done && (paddr == REG_IRQ_EN)) begin
      s_nxt.irq_en = pwdata[1:0];
    end
    if (wr_done && (paddr == REG_IRQ_CLR)) begin
      irq_clr = pwdata[1:0];
    end

    if (s_r.dout_valid && dout_ready) begin
      s_nxt.dout_valid = 1'b0;
    end

    case (s_r.fsm)
      ST_IDLE: begin
        if (start) begin
          s_nxt.busy  = 1'b1;
          s_nxt.idx   = 24'h00_0000;
          s_nxt.check = 1'b0;
          s_nxt.sense = SENSE_NONE;
          if (dec.reject) begin
            s_nxt.check = 1'b1; // RL2 RL11 RL18
            s_nxt.sense = SENSE_ILLEGAL; // RL2 RL11 RL18
            s_nxt.fsm   = ST_FIN;
          end else if (dec.is_write) begin
            s_nxt.fsm       = ST_RECV;
            s_nxt.din_ready = (dec.total != 24'h00_0000);
          end else begin
            s_nxt.fsm = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (!s_nxt.dout_valid) begin
          if (s_r.idx < dec.total) begin // RL7 RL13 RL15
            s_nxt.dout_byte  = gen_byte;
            s_nxt.dout_valid = 1'b1;
            s_nxt.idx        = s_r.idx + 24'h00_0001;
          end else begin
            s_nxt.fsm = ST_FIN;
          end
        end
      end
      ST_RECV: begin
        if (din_valid && s_r.din_ready) begin
          // Bytes ahead of the payload are the echoed header and are dropped
          if (s_r.idx >= hdr24) begin // RL1
            s_nxt.mem[mem_ix] = din_byte;
          end
          s_nxt.idx = s_r.idx + 24'h00_0001;
        end
        s_nxt.din_ready = (s_nxt.idx < dec.total);
        if (!s_nxt.din_ready) begin
          s_nxt.fsm = ST_FIN;
        end
      end
      ST_FIN: begin
        s_nxt.busy = 1'b0;
        s_nxt.fsm  = ST_IDLE;
        irq_set[IRQ_DONE]  = 1'b1;
        irq_set[IRQ_CHECK] = s_r.check;
        if (dec.is_write && !s_r.check) begin
          s_nxt.avail = s_r.idx - hdr24;
        end
      end
      default: begin
        s_nxt.fsm = ST_IDLE;
      end
    endcase

    // A new event wins over a clear in the same cycle
    s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.avail <= AVAIL_RST;
      s_r.irq_en <= IRQ_EN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata     = s_r.prdata;
  assign pready     = s_r.pready;
  assign pslverr    = s_r.pslverr;
  assign dout_byte  = s_r.dout_byte;
  assign dout_valid = s_r.dout_valid;
  assign din_ready  = s_r.din_ready;
  assign irq        = s_r.irq;

endmodule : diag_buf_engine
`default_nettype wire

// >>> verification/diag_buf_assertions.sv
/* Port checker for the buffer-access command engine.
   Assumes it is bound onto diag_buf_engine, one clock domain on pclk. */
`timescale 1ns/100ps
`default_nettype none
module diag_buf_assertions
  import diag_buf_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Streams
  input wire logic [7:0]  dout_byte,
  input wire logic        dout_valid,
  input wire logic        dout_ready,
  input wire logic [7:0]  din_byte,
  input wire logic        din_valid,
  input wire logic        din_ready,
  // Interrupt
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic done_w;
  logic clr_w;
  assign done_w = psel && penable && pready;
  assign clr_w  = done_w && pwrite && (paddr == REG_IRQ_CLR || paddr == REG_IRQ_EN);
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  property p_ready_wait; s_access |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_zero; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  property p_unmapped; done_w && paddr > REG_IRQ_EN |-> pslverr; endproperty
  property p_ctrl_zero; done_w && !pwrite && paddr == REG_CTRL |-> prdata == 32'h0000_0000; endproperty
  property p_hold; dout_valid && !dout_ready |=> dout_valid && $stable(dout_byte); endproperty
  property p_one_dir; !(dout_valid && din_ready); endproperty
  // Clearing or masking reaches irq at the very edge at which the write lands
  property p_irq_hold; irq && !clr_w |=> irq; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready missing after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_err_zero: assert property (p_err_zero) else $error("pslverr without pready or with data");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control register read not zero");
  a_hold: assert property (p_hold) else $error("data-in byte dropped or changed");
  a_one_dir: assert property (p_one_dir) else $error("both streams active");
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell without clear");
endmodule : diag_buf_assertions
bind diag_buf_engine diag_buf_assertions diag_buf_assertions_i (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .dout_byte, .dout_valid, .dout_ready, .din_byte, .din_valid,
  .din_ready, .irq);
`default_nettype wire

// >>> verification/initiator_model.sv
/* Initiator on the far side of the byte streams: sinks data-in, sources data-out.
   Assumes the testbench fills tx_q and empties rx_q around each command. */
`timescale 1ns/100ps
`default_nettype none
module initiator_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Data-in
  input  wire logic [7:0] dout_byte,
  input  wire logic       dout_valid,
  output logic            dout_ready,
  // Data-out
  output logic      [7:0] din_byte,
  output logic            din_valid,
  input  wire logic       din_ready
);
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  int         seed = 32'h5a5a_0001;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_ready <= 1'b0;
      din_valid  <= 1'b0;
      din_byte   <= 8'h00;
    end else begin
      if (dout_valid && dout_ready) rx_q.push_back(dout_byte);
      // Random stalls on both streams
      dout_ready <= ($random(seed) & 32'h0000_0003) != 0;
      if (din_valid && din_ready) begin
        void'(tx_q.pop_front());
        din_valid <= 1'b0;
        // Released line shows the inverse, never the last byte
        din_byte  <= ~din_byte;
      end else if (!din_valid && tx_q.size() > 0 && $random(seed) & 32'h0000_0001) begin
        din_valid <= 1'b1;
        din_byte  <= tx_q[0];
      end
    end
  end
endmodule : initiator_model
`default_nettype wire

// >>> verification/testbench.sv
/* Self-checking bench: APB master, random writes and reads in every mode, rejects, interrupt.
   Assumes the engine and the initiator model share pclk. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import diag_buf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, dout_byte, din_byte;
  logic [31:0] pwdata, prdata, rd;
  logic        dout_valid, dout_ready, din_valid, din_ready, e;
  logic [7:0]  mem_m[64], m, s;
  logic [23:0] avail_m, wl;
  int          fail_count = 0, n_checks = 0, seed = 32'h0c7a_2530, k, j, i, n, a;
  logic [7:0]  rst_a[5] = '{REG_STATUS, REG_AVAIL, REG_IRQ_STAT, REG_IRQ_EN, REG_CTRL};
  logic [7:0]  rmode[3] = '{MODE_COMBINED, MODE_DATA, MODE_DESC};
  logic [7:0]  rj_op[7] = '{OP_READ_BUF, OP_READ_BUF, OP_WRITE_BUF, OP_WRITE_BUF, OP_WRITE_BUF, OP_READ_BUF, 8'h12};
  logic [7:0]  rj_m[7] = '{MODE_DATA, 8'h01, MODE_COMBINED, 8'h01, MODE_DATA, 8'h07, MODE_DATA};
  logic [23:0] rj_l[7] = '{24'h00_0008, 24'h00_0008, 24'h00_0045, 24'h00_0008, 24'h00_0041, 24'h00_0008,
                           24'h00_0008};
  diag_buf_engine diag_buf_engine_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .dout_byte, .dout_valid, .dout_ready, .din_byte, .din_valid, .din_ready, .irq);
  initiator_model initiator_model_i (.pclk, .presetn, .dout_byte, .dout_valid, .dout_ready, .din_byte,
    .din_valid, .din_ready);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int t;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (t == 20) begin fail_count++; print_verdict(); end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic irq_is(input logic x);
    repeat (3) @(posedge pclk);
    #1 check(irq, x); // irq level follows enabled status
    @(posedge pclk);
  endtask : irq_is
  function automatic logic [7:0] exp_byte(input logic [2:0] md, input logic [7:0] sl, input int x);
    logic [31:0] h;
    h = (md == MODE_DESC) ? ((sl != 0) ? 32'h0000_0000 : {8'h00, BUF_CAPACITY}) : {8'h00, avail_m};
    if (md == MODE_DATA) return mem_m[x];
    if (x < 4) return h[31-8*x -: 8];
    return mem_m[x-4];
  endfunction : exp_byte
  function automatic int exp_count(input logic [2:0] md, input int al);
    int lim;
    lim = (md == MODE_DESC) ? 4 : (md == MODE_DATA) ? int'(avail_m) : int'(avail_m) + 4;
    return (al < lim) ? al : lim;
  endfunction : exp_count
  task automatic run(input logic [7:0] op, md, sl, input logic [23:0] len, input logic rej);
    int t, c;
    initiator_model_i.rx_q.delete();
    apb(1'b1, REG_CMD_LO, {8'h00, sl, md, op});
    apb(1'b1, REG_CMD_MID, {len[15:8], len[23:16], 16'h0000});
    apb(1'b1, REG_CMD_HI, {24'h00_0000, len[7:0]});
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    rd = 32'h0000_0001;
    for (t = 0; t < 500 && rd[ST_BUSY] !== 1'b0; t++) apb(1'b0, REG_STATUS, 32'h0000_0000);
    if (t == 500) begin fail_count++; print_verdict(); end
    check(rd, rej ? 32'h0000_0052 : 32'h0000_0000);
    c = (op == OP_READ_BUF && !rej) ? exp_count(md[2:0], int'(len)) : 0;
    check(initiator_model_i.rx_q.size(), c);
    for (t = 0; t < c && t < initiator_model_i.rx_q.size(); t++)
      check(initiator_model_i.rx_q[t], exp_byte(md[2:0], sl, t));
    initiator_model_i.tx_q.delete();
  endtask : run
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rst_a[x]) begin
      apb(1'b0, rst_a[x], 32'h0000_0000);
      check(rd, 32'h0000_0000); // reset values
      check(e, 1'b0); // mapped access raises no error
    end
    apb(1'b0, 8'h24, 32'h0000_0000);
    check({e, rd[30:0]}, 32'h8000_0000); // unmapped address
    apb(1'b1, REG_IRQ_EN, 32'h0000_0003);
    for (k = 0; k < 6; k++) begin
      n = (k == 0) ? BUF_BYTES : ($unsigned($random(seed)) % 64) + 1;
      m = k[0] ? MODE_DATA : MODE_COMBINED;
      wl = k[0] ? n : n + 4;
      if (!k[0]) begin
        initiator_model_i.tx_q = '{m, wl[23:16], wl[15:8], wl[7:0]};
      end
      for (i = 0; i < n; i++) begin
        mem_m[i] = $random(seed);
        initiator_model_i.tx_q.push_back(mem_m[i]);
      end
      run(OP_WRITE_BUF, m, 8'h00, wl, 1'b0);
      avail_m = n;
      apb(1'b0, REG_AVAIL, 32'h0000_0000);
      check(rd, n);
      for (j = 0; j < 3; j++) begin
        a = (k == 0) ? 64 : (k == 1) ? 0 : ($unsigned($random(seed)) % 64) + 1;
        s = (j == 1) ? 8'h00 : 8'(k & 1);
        run(OP_READ_BUF, rmode[j], s, a, 1'b0);
      end
    end
    irq_is(1'b1);
    apb(1'b1, REG_IRQ_CLR, 32'h0000_0003);
    irq_is(1'b0);
    apb(1'b1, REG_IRQ_EN, 32'h0000_0000);
    for (k = 0; k < 7; k++) run(rj_op[k], rj_m[k], 8'(k == 0), rj_l[k], 1'b1);
    irq_is(1'b0);
    apb(1'b0, REG_IRQ_STAT, 32'h0000_0000);
    check(rd, 32'h0000_0003); // sticky status while masked
    apb(1'b1, REG_IRQ_EN, 32'h0000_0003);
    irq_is(1'b1);
    apb(1'b1, REG_IRQ_CLR, 32'h0000_0003);
    irq_is(1'b0);
    run(OP_READ_BUF, MODE_DESC, 8'h00, 24'h00_0010, 1'b0);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
